// ===== logic/omc_pkg.sv
// operating-mode controller: constants, register map and field layout
// assumes one 50 MHz clock and an apb slave port on the top module
//
// Functional notes
// - three modes; stop halts the program but keeps i/o refreshing
// - test-run executes and accepts edits, forcing and memory writes
// - normal-run executes, refuses edits/forcing/writes, allows monitoring
// - stop to/from run clears non-held areas; run to test keeps all
// - relay and link are non-held areas; timer values and flags are a group of their own
// - holding, data, extended memory and counters survive mode changes
// - entering stop from a running mode keeps timer values and flags
// - entering a running mode from stop clears timer values and flags
// - io hold bit set keeps i/o memory across mode changes
// - fatal stop with io hold keeps memory but forces outputs off
// - startup high byte: 00 switch/device, 01 last mode, 02 low byte
// - startup low byte: 00 stop, 01 test-run, 02 normal-run
// - pin 7 off: none stop, console its switch, other stop refused
// - pin 7 on: none run, console stop refused, other by cable
// - pin 2 on copies cassette contents into the cpu at power-on
// - without battery held areas are lost and system area undefined
// - battery error suppressed by setting in setup bits 12 to 15
package omc_pkg;
	localparam logic [1:0] MODE_STOP = 2'h0;
	localparam logic [1:0] MODE_TEST = 2'h1;
	localparam logic [1:0] MODE_RUN = 2'h2;
	localparam logic [7:0] SEL_SWITCH = 8'h00;
	localparam logic [7:0] SEL_LAST = 8'h01;
	localparam logic [7:0] SEL_WORD = 8'h02;
	localparam logic [7:0] LOW_STOP = 8'h00;
	localparam logic [7:0] LOW_TEST = 8'h01;
	localparam logic [7:0] LOW_RUN = 8'h02;
	localparam logic [1:0] DEV_NONE = 2'h0;
	localparam logic [1:0] DEV_CONSOLE = 2'h1;
	localparam logic [1:0] DEV_OTHER = 2'h2;
	localparam logic [1:0] REQ_EDIT = 2'h0;
	localparam logic [1:0] REQ_FORCE = 2'h1;
	localparam logic [1:0] REQ_WRITE = 2'h2;
	localparam logic [1:0] REQ_MONITOR = 2'h3;
	localparam logic [11:0] ADDR_STARTUP = 12'h000;
	localparam logic [11:0] ADDR_HOLD = 12'h004;
	localparam logic [11:0] ADDR_BATT = 12'h008;
	localparam logic [11:0] ADDR_MODE_REQ = 12'h00c;
	localparam logic [11:0] ADDR_STATUS = 12'h010;
	localparam logic [15:0] STARTUP_RST = 16'h0000;
	localparam logic [2:0] HOLD_RST = 3'h0;
	localparam logic [3:0] BATT_RST = 4'h0;
	localparam logic [3:0] BATT_SUPPRESS = 4'h1;
	localparam int BIT_IO_HOLD = 0;
	localparam int BIT_FORCE_HOLD = 1;
	localparam int BIT_OUT_OFF = 2;
	localparam int BATT_LSB = 12;
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_FATAL = 2;
	localparam int STAT_REFUSED = 3;
	localparam int STAT_BATT_ERR = 4;
	localparam int STAT_SYS_UNDEF = 5;
	localparam int STAT_READY = 6;
	localparam int STAT_XFER = 7;
	typedef enum logic [3:0] {
		BT_POWER = 4'b0001,
		BT_XFER = 4'b0010,
		BT_DECIDE = 4'b0100,
		BT_OPER = 4'b1000
	} omc_boot_t;
endpackage : omc_pkg

// ===== logic/omc_startup.sv
// power-on mode selection from startup word, pin 7 and attached device
// assumes all inputs stable while the boot sequencer samples the result
`timescale 1ns/1ns
`default_nettype none
module omc_startup (
	input wire logic [15:0] startup_word,
	input wire logic [1:0] last_mode,
	input wire logic pin7,
	input wire logic [1:0] dev_type,
	input wire logic [1:0] console_mode,
	input wire logic cable_run,
	output logic [1:0] boot_mode,
	output logic comm_refused
);
	always_comb
	begin
		boot_mode = omc_pkg::MODE_STOP;
		comm_refused = 1'b0;
		unique case (startup_word[15:8])
			omc_pkg::SEL_LAST:
				boot_mode = last_mode;
			omc_pkg::SEL_WORD:
			begin
				unique case (startup_word[7:0])
					omc_pkg::LOW_TEST: boot_mode = omc_pkg::MODE_TEST;
					omc_pkg::LOW_RUN: boot_mode = omc_pkg::MODE_RUN;
					default: boot_mode = omc_pkg::MODE_STOP;
				endcase
			end
			omc_pkg::SEL_SWITCH:
			begin
				if (!pin7)
				begin
					if (dev_type == omc_pkg::DEV_CONSOLE)
						boot_mode = console_mode;
					comm_refused = (dev_type == omc_pkg::DEV_OTHER);
				end
				else
				begin
					if (dev_type == omc_pkg::DEV_NONE)
						boot_mode = omc_pkg::MODE_RUN;
					else if (dev_type == omc_pkg::DEV_OTHER && cable_run)
						boot_mode = omc_pkg::MODE_RUN;
					comm_refused = (dev_type == omc_pkg::DEV_CONSOLE);
				end
			end
			// undefined selector codes fall back to stop
			default: boot_mode = omc_pkg::MODE_STOP;
		endcase
		// code 3 names no mode: a bad console or saved value starts in stop
		if (boot_mode == 2'h3)
			boot_mode = omc_pkg::MODE_STOP;
	end
endmodule : omc_startup
`default_nettype wire

// ===== logic/omc_transition.sv
// which i/o memory groups a mode change clears
// assumes old and new mode differ when the result is used
`timescale 1ns/1ns
`default_nettype none
module omc_transition (
	input wire logic [1:0] old_mode,
	input wire logic [1:0] new_mode,
	input wire logic io_hold,
	output logic clr_nonheld,
	output logic clr_timer
);
	logic old_stop;
	logic new_stop;
	assign old_stop = (old_mode == omc_pkg::MODE_STOP);
	assign new_stop = (new_mode == omc_pkg::MODE_STOP);
	// held areas (holding, data, extended, counters) are never cleared by a mode change
	always_comb
	begin
		clr_nonheld = (old_stop != new_stop) && !io_hold;
		clr_timer = old_stop && !new_stop && !io_hold;
	end
endmodule : omc_transition
`default_nettype wire

// ===== logic/omc_mode_ctrl.sv
// operating-mode controller top: boot sequencing, mode changes, apb regs
// assumes synchronous pin inputs and a battery-backed mode store outside
`timescale 1ns/1ns
`default_nettype none
module omc_mode_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic dip_autoxfer,
	input wire logic dip_any_device,
	input wire logic [1:0] dev_type,
	input wire logic [1:0] console_mode,
	input wire logic cable_run,
	input wire logic battery_ok,
	input wire logic fatal_error,
	input wire logic xfer_done,
	input wire logic [1:0] saved_mode,
	input wire logic req_valid,
	input wire logic [1:0] req_kind,
	output logic req_done,
	output logic req_ok,
	output logic [1:0] mode,
	output logic prog_exec,
	output logic io_refresh,
	output logic outputs_off,
	output logic clr_nonheld,
	output logic clr_timer,
	output logic clr_held,
	output logic xfer_start,
	output logic save_wr,
	output logic [1:0] save_mode
);
	omc_pkg::omc_boot_t boot_reg;
	logic [15:0] startup_reg;
	logic [2:0] hold_reg;
	logic [3:0] batt_reg;
	logic [1:0] mode_reg;
	logic [1:0] mode_req_reg;
	logic mode_req_pend;
	logic fatal_reg;
	logic refused_reg;
	logic batt_err_reg;
	logic sys_undef_reg;
	logic [1:0] boot_mode;
	logic boot_refused;
	logic [1:0] target;
	logic chg;
	logic t_clr_nonheld;
	logic t_clr_timer;
	logic access;
	logic wr_fire;
	logic addr_ok;
	logic [31:0] rd_next;
	logic io_hold;

	assign io_hold = hold_reg[omc_pkg::BIT_IO_HOLD];
	assign mode = mode_reg;

	omc_startup u_startup (
		.startup_word(startup_reg),
		.last_mode(saved_mode),
		.pin7(dip_any_device),
		.dev_type(dev_type),
		.console_mode(console_mode),
		.cable_run(cable_run),
		.boot_mode(boot_mode),
		.comm_refused(boot_refused)
	);

	omc_transition u_trans (
		.old_mode(mode_reg),
		.new_mode(target),
		.io_hold(io_hold),
		.clr_nonheld(t_clr_nonheld),
		.clr_timer(t_clr_timer)
	);

	// apb: one wait state so read data comes from a flop
	assign access = psel && penable && !pready;
	assign wr_fire = psel && penable && pready && pwrite;
	always_comb
	begin
		addr_ok = 1'b1;
		rd_next = 32'h0000_0000;
		unique case (paddr)
			omc_pkg::ADDR_STARTUP: rd_next[15:0] = startup_reg;
			omc_pkg::ADDR_HOLD: rd_next[2:0] = hold_reg;
			omc_pkg::ADDR_BATT: rd_next[omc_pkg::BATT_LSB +: 4] = batt_reg;
			omc_pkg::ADDR_MODE_REQ: rd_next[1:0] = mode_req_reg;
			omc_pkg::ADDR_STATUS:
			begin
				rd_next[omc_pkg::STAT_MODE_LSB +: 2] = mode_reg;
				rd_next[omc_pkg::STAT_FATAL] = fatal_reg;
				rd_next[omc_pkg::STAT_REFUSED] = refused_reg;
				rd_next[omc_pkg::STAT_BATT_ERR] = batt_err_reg;
				rd_next[omc_pkg::STAT_SYS_UNDEF] = sys_undef_reg;
				rd_next[omc_pkg::STAT_READY] = (boot_reg == omc_pkg::BT_OPER);
				rd_next[omc_pkg::STAT_XFER] = (boot_reg == omc_pkg::BT_XFER);
			end
			default: addr_ok = 1'b0;
		endcase
		// mode code 3 does not exist
		if (pwrite && paddr == omc_pkg::ADDR_MODE_REQ && pwdata[1:0] == 2'h3)
			addr_ok = 1'b0;
		if (pwrite && paddr == omc_pkg::ADDR_STATUS)
			addr_ok = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= access;
			pslverr <= access && !addr_ok;
			if (access)
				prdata <= pwrite ? 32'h0000_0000 : rd_next;
		end
	end

	// software-visible setup words
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			startup_reg <= omc_pkg::STARTUP_RST;
			hold_reg <= omc_pkg::HOLD_RST;
			batt_reg <= omc_pkg::BATT_RST;
		end
		else if (wr_fire && !pslverr)
		begin
			if (paddr == omc_pkg::ADDR_STARTUP)
				startup_reg <= pwdata[15:0];
			if (paddr == omc_pkg::ADDR_HOLD)
				hold_reg <= pwdata[2:0];
			if (paddr == omc_pkg::ADDR_BATT)
				batt_reg <= pwdata[omc_pkg::BATT_LSB +: 4];
		end
	end

	// a mode request waits until the boot sequence is over
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_req_reg <= omc_pkg::MODE_STOP;
			mode_req_pend <= 1'b0;
		end
		else if (wr_fire && !pslverr && paddr == omc_pkg::ADDR_MODE_REQ)
		begin
			mode_req_reg <= pwdata[1:0];
			mode_req_pend <= 1'b1;
		end
		else if (boot_reg == omc_pkg::BT_OPER)
			mode_req_pend <= 1'b0;
	end

	// fatal stop overrides any pending request
	always_comb
	begin
		target = mode_reg;
		if (fatal_error)
			target = omc_pkg::MODE_STOP;
		else if (mode_req_pend && !fatal_reg)
			target = mode_req_reg;
	end
	assign chg = (boot_reg == omc_pkg::BT_OPER) && (target != mode_reg);

	// boot sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			boot_reg <= omc_pkg::BT_POWER;
		else
		begin
			unique case (boot_reg)
				omc_pkg::BT_POWER:
					boot_reg <= dip_autoxfer ? omc_pkg::BT_XFER
						: omc_pkg::BT_DECIDE;
				omc_pkg::BT_XFER:
					if (xfer_done)
						boot_reg <= omc_pkg::BT_DECIDE;
				omc_pkg::BT_DECIDE:
					boot_reg <= omc_pkg::BT_OPER;
				omc_pkg::BT_OPER:
					boot_reg <= omc_pkg::BT_OPER;
			endcase
		end
	end

	// cassette copy: program, read-only data, setup, expansion info
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			xfer_start <= 1'b0;
		else
			xfer_start <= (boot_reg == omc_pkg::BT_POWER) && dip_autoxfer;
	end

	// lost held data without battery; system area then untrusted
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clr_held <= 1'b0;
			sys_undef_reg <= 1'b0;
		end
		else
		begin
			clr_held <= (boot_reg == omc_pkg::BT_POWER) && !battery_ok;
			if (boot_reg == omc_pkg::BT_POWER)
				sys_undef_reg <= !battery_ok;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			batt_err_reg <= 1'b0;
		else
			batt_err_reg <= !battery_ok && batt_reg != omc_pkg::BATT_SUPPRESS;
	end

	// mode register and the clears that go with each change
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_reg <= omc_pkg::MODE_STOP;
			prog_exec <= 1'b0;
			refused_reg <= 1'b0;
			clr_nonheld <= 1'b0;
			clr_timer <= 1'b0;
			save_wr <= 1'b0;
			save_mode <= omc_pkg::MODE_STOP;
		end
		else
		begin
			clr_nonheld <= 1'b0;
			clr_timer <= 1'b0;
			save_wr <= 1'b0;
			if (boot_reg == omc_pkg::BT_DECIDE)
			begin
				mode_reg <= boot_mode;
				prog_exec <= boot_mode != omc_pkg::MODE_STOP;
				refused_reg <= boot_refused;
			end
			else if (chg)
			begin
				mode_reg <= target;
				prog_exec <= target != omc_pkg::MODE_STOP;
				clr_nonheld <= t_clr_nonheld;
				clr_timer <= t_clr_timer;
				save_wr <= 1'b1;
				save_mode <= target;
			end
		end
	end

	// fatal stop: set wins over the release
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fatal_reg <= 1'b0;
		else if (fatal_error)
			fatal_reg <= 1'b1;
		else if (mode_req_pend && mode_req_reg == omc_pkg::MODE_STOP)
			fatal_reg <= 1'b0;
	end

	// with io hold a fatal stop keeps memory, so outputs must be cut here
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			outputs_off <= 1'b0;
			io_refresh <= 1'b0;
		end
		else
		begin
			outputs_off <= (fatal_error || fatal_reg)
				|| hold_reg[omc_pkg::BIT_OUT_OFF];
			io_refresh <= boot_reg == omc_pkg::BT_OPER;
		end
	end

	// programming device requests
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			req_done <= 1'b0;
			req_ok <= 1'b0;
		end
		else
		begin
			req_done <= req_valid;
			if (refused_reg || boot_reg != omc_pkg::BT_OPER)
				req_ok <= 1'b0;
			else if (mode_reg == omc_pkg::MODE_RUN)
				req_ok <= req_kind == omc_pkg::REQ_MONITOR;
			else
				req_ok <= 1'b1;
		end
	end

	a_run_refuses: assert property (@(posedge pclk) disable iff (!presetn)
		req_valid && mode_reg == omc_pkg::MODE_RUN
		&& req_kind != omc_pkg::REQ_MONITOR |=> req_done && !req_ok)
		else $error("run mode accepted a change request");
	a_test_accepts: assert property (@(posedge pclk) disable iff (!presetn)
		req_valid && mode_reg == omc_pkg::MODE_TEST && !refused_reg
		&& boot_reg == omc_pkg::BT_OPER |=> req_done && req_ok)
		else $error("test mode refused a request");
	a_exec_mode: assert property (@(posedge pclk) disable iff (!presetn)
		prog_exec == (mode_reg != omc_pkg::MODE_STOP))
		else $error("program execution disagrees with mode");
	a_stop_to_run: assert property (@(posedge pclk) disable iff (!presetn)
		chg && mode_reg == omc_pkg::MODE_STOP && !io_hold
		|=> clr_timer && clr_nonheld && prog_exec)
		else $error("start from stop did not clear timers");
	a_run_to_stop: assert property (@(posedge pclk) disable iff (!presetn)
		chg && target == omc_pkg::MODE_STOP && !io_hold
		|=> !clr_timer && clr_nonheld)
		else $error("stop entry cleared timers or kept non-held");
	a_run_to_test: assert property (@(posedge pclk) disable iff (!presetn)
		chg && mode_reg != omc_pkg::MODE_STOP
		&& target != omc_pkg::MODE_STOP |=> !clr_nonheld && !clr_timer)
		else $error("run to test change cleared memory");
	a_hold_keeps: assert property (@(posedge pclk) disable iff (!presetn)
		chg && io_hold |=> !clr_nonheld && !clr_timer)
		else $error("io hold did not keep memory");
	a_fatal_off: assert property (@(posedge pclk) disable iff (!presetn)
		fatal_error && boot_reg == omc_pkg::BT_OPER
		|=> outputs_off && mode_reg == omc_pkg::MODE_STOP)
		else $error("fatal error left outputs on");
	a_xfer_boot: assert property (@(posedge pclk) disable iff (!presetn)
		boot_reg == omc_pkg::BT_POWER && dip_autoxfer
		|=> xfer_start && boot_reg == omc_pkg::BT_XFER)
		else $error("cassette copy not started");
	a_batt_err: assert property (@(posedge pclk) disable iff (!presetn)
		!battery_ok && batt_reg == omc_pkg::BATT_SUPPRESS |=> !batt_err_reg)
		else $error("suppressed battery error reported");
	a_save_mode: assert property (@(posedge pclk) disable iff (!presetn)
		chg |=> save_wr && save_mode == mode_reg)
		else $error("mode change not saved");
	a_boot_run: assert property (@(posedge pclk) disable iff (!presetn)
		boot_reg == omc_pkg::BT_DECIDE && startup_reg[15:8] == 8'h00
		&& dip_any_device && dev_type == omc_pkg::DEV_NONE
		|=> mode_reg == omc_pkg::MODE_RUN)
		else $error("pin 7 boot with nothing attached not run");
	c_boot_xfer: cover property (@(posedge pclk) disable iff (!presetn)
		xfer_start ##[1:20] boot_reg == omc_pkg::BT_OPER);
	c_stop_run: cover property (@(posedge pclk) disable iff (!presetn)
		chg && mode_reg == omc_pkg::MODE_STOP);
	c_fatal: cover property (@(posedge pclk) disable iff (!presetn)
		fatal_error && io_hold && mode_reg == omc_pkg::MODE_RUN);
	c_refused: cover property (@(posedge pclk) disable iff (!presetn)
		req_done && !req_ok);
endmodule : omc_mode_ctrl
`default_nettype wire

// ===== dv/omc_console_model.sv
// programming console model on the peripheral port
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ns
`default_nettype none
module omc_console_model (
	input wire logic pclk,
	output logic [1:0] dev_type,
	output logic [1:0] console_mode,
	output logic cable_run,
	output logic req_valid,
	output logic [1:0] req_kind,
	input wire logic req_done,
	input wire logic req_ok
);
	initial
	begin
		dev_type = 2'h0;
		console_mode = 2'h0;
		cable_run = 1'b0;
		req_valid = 1'b0;
		req_kind = 2'h3;
	end
	task automatic attach(input logic [1:0] t, input logic [1:0] m,
		input logic c);
	begin
		@(posedge pclk);
		dev_type <= t;
		console_mode <= m;
		cable_run <= c;
	end
	endtask : attach
	// answer is taken one edge after acceptance; a missing answer reads x
	task automatic send_req(input logic [1:0] k, output logic ok);
	begin
		@(posedge pclk);
		req_valid <= 1'b1;
		req_kind <= k;
		@(posedge pclk);
		req_valid <= 1'b0;
		req_kind <= ~k; // idle kind flips so a stale latch shows up
		@(posedge pclk);
		ok = req_done ? req_ok : 1'bx;
	end
	endtask : send_req
endmodule : omc_console_model
`default_nettype wire

// ===== dv/omc_mode_ctrl_tb.sv
// self-checking bench for the operating-mode controller
// assumes the console model and an apb master task drive the device and bus inputs
`timescale 1ns/1ns
`default_nettype none
module omc_mode_ctrl_tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, e, ok, cn, ct, sw;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic dip_autoxfer = 1'b0, dip_any_device = 1'b0, battery_ok = 1'b1;
	logic fatal_error = 1'b0, xfer_done = 1'b0, xfer_stall = 1'b0;
	logic [1:0] saved_mode = 2'h0, dev_type, console_mode, req_kind, sm;
	logic cable_run, req_valid, req_done, req_ok, prog_exec, io_refresh;
	logic outputs_off, clr_nonheld, clr_timer, clr_held, xfer_start, save_wr;
	logic [1:0] mode, save_mode;
	int failures = 0, checks = 0, xfer_cnt = 0, held_cnt = 0;
	logic [8:0] tbl [7] = '{9'h000, 9'h062, 9'h084, 9'h102, 9'h164,
		9'h18a, 9'h180};
	// {expected boot mode, startup word}
	logic [17:0] st_tbl [4] = '{18'h10201, 18'h20202, 18'h20100,
		18'h00300};
	omc_mode_ctrl dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dip_autoxfer(dip_autoxfer), .dip_any_device(dip_any_device),
		.dev_type(dev_type), .console_mode(console_mode),
		.cable_run(cable_run), .battery_ok(battery_ok),
		.fatal_error(fatal_error), .xfer_done(xfer_done),
		.saved_mode(saved_mode), .req_valid(req_valid), .req_kind(req_kind),
		.req_done(req_done), .req_ok(req_ok), .mode(mode),
		.prog_exec(prog_exec), .io_refresh(io_refresh),
		.outputs_off(outputs_off), .clr_nonheld(clr_nonheld),
		.clr_timer(clr_timer), .clr_held(clr_held), .xfer_start(xfer_start),
		.save_wr(save_wr), .save_mode(save_mode));
	omc_console_model pdev (.pclk(pclk), .dev_type(dev_type),
		.console_mode(console_mode), .cable_run(cable_run),
		.req_valid(req_valid), .req_kind(req_kind), .req_done(req_done),
		.req_ok(req_ok));
	always #10 pclk = ~pclk;
	// cassette reports done as a level unless a test parks the boot
	always @(posedge pclk)
	begin
		xfer_done <= !xfer_stall;
		if (!presetn)
		begin
			xfer_cnt <= 0;
			held_cnt <= 0;
		end
		else
		begin
			if (xfer_start)
				xfer_cnt <= xfer_cnt + 1;
			if (clr_held)
				held_cnt <= held_cnt + 1;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
	begin
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
	begin
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no cycle count assumed: only the watchdog ends a stuck wait
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask : apb
	task automatic wait_mode(input logic [1:0] m);
		int n;
	begin
		n = 0;
		while (mode !== m && n < 10)
		begin
			@(posedge pclk);
			#1;
			n++;
		end
		if (mode !== m)
			failures++;
		{cn, ct, sw, sm} = {clr_nonheld, clr_timer, save_wr, save_mode};
	end
	endtask : wait_mode
	task automatic go_mode(input logic [1:0] m);
	begin
		apb(1'b1, omc_pkg::ADDR_MODE_REQ, {30'h0, m});
		wait_mode(m);
	end
	endtask : go_mode
	task automatic rst_pulse;
	begin
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
	end
	endtask : rst_pulse
	task automatic wait_ready;
		int n;
	begin
		n = 0;
		q = 32'h0;
		while (q[omc_pkg::STAT_READY] !== 1'b1 && n < 10)
		begin
			apb(1'b0, omc_pkg::ADDR_STATUS, 32'h0);
			n++;
		end
		if (q[omc_pkg::STAT_READY] !== 1'b1)
			failures++;
	end
	endtask : wait_ready
	task automatic do_reset;
	begin
		rst_pulse();
		wait_ready();
	end
	endtask : do_reset
	task automatic t_regs;
	begin
		apb(1'b0, omc_pkg::ADDR_STARTUP, 32'h0);
		chk(q, {16'h0, omc_pkg::STARTUP_RST});
		apb(1'b1, omc_pkg::ADDR_STARTUP, 32'h0000_0201);
		apb(1'b0, omc_pkg::ADDR_STARTUP, 32'h0);
		chk(q, 32'h0000_0201);
		apb(1'b0, 12'hffc, 32'h0);
		chk(e, 1'b1);
		apb(1'b1, omc_pkg::ADDR_STATUS, 32'h0000_00ff);
		chk(e, 1'b1);
	end
	endtask : t_regs
	task automatic t_boot;
	begin
		for (int i = 0; i < 7; i++)
		begin
			pdev.attach(tbl[i][7:6], tbl[i][5:4], tbl[i][3]);
			dip_any_device <= tbl[i][8];
			do_reset();
			chk(q[3:0], {tbl[i][2], 1'b0, tbl[i][1:0]});
		end
	end
	endtask : t_boot
	task automatic t_modes;
	begin
		go_mode(omc_pkg::MODE_TEST);
		chk({cn, ct, sw, sm, prog_exec}, 6'h3b);
		for (int k = 0; k < 4; k++)
		begin
			pdev.send_req(k[1:0], ok);
			chk(ok, 1'b1);
		end
		go_mode(omc_pkg::MODE_RUN);
		chk({cn, ct, sw, sm}, 5'h06);
		for (int k = 0; k < 4; k++)
		begin
			pdev.send_req(k[1:0], ok);
			chk(ok, k == 3);
		end
		go_mode(omc_pkg::MODE_STOP);
		chk({cn, ct, sw, sm, prog_exec, io_refresh}, 7'h51);
		chk(held_cnt[3:0], 4'h0);
		apb(1'b1, omc_pkg::ADDR_MODE_REQ, 32'h3);
		chk({e, mode}, 3'h4);
	end
	endtask : t_modes
	task automatic t_hold;
	begin
		apb(1'b1, omc_pkg::ADDR_HOLD, 32'h1);
		go_mode(omc_pkg::MODE_TEST);
		chk(cn, 1'b0);
		@(posedge pclk);
		fatal_error <= 1'b1;
		wait_mode(omc_pkg::MODE_STOP);
		chk({mode, outputs_off, cn}, 4'h2);
		@(posedge pclk);
		fatal_error <= 1'b0;
		apb(1'b1, omc_pkg::ADDR_MODE_REQ, 32'h0);
		apb(1'b1, omc_pkg::ADDR_HOLD, 32'h0);
		go_mode(omc_pkg::MODE_TEST);
		chk(mode, omc_pkg::MODE_TEST);
	end
	endtask : t_hold
	// hold bits are never made maintained here, as battery-less use needs
	task automatic t_battery;
	begin
		@(posedge pclk);
		battery_ok <= 1'b0;
		dip_autoxfer <= 1'b1;
		do_reset();
		chk({xfer_cnt[3:0], held_cnt[3:0]}, 8'h11);
		chk(q[5:4], 2'h3);
		apb(1'b1, omc_pkg::ADDR_HOLD, 32'h0);
		apb(1'b1, omc_pkg::ADDR_BATT, {16'h0, omc_pkg::BATT_SUPPRESS, 12'h0});
		apb(1'b0, omc_pkg::ADDR_STATUS, 32'h0);
		chk(q[4], 1'b0);
	end
	endtask : t_battery
	// boot parks in the copy state so the startup word can be set first
	task automatic t_startup;
	begin
		saved_mode <= omc_pkg::MODE_RUN;
		for (int i = 0; i < 4; i++)
		begin
			xfer_stall <= 1'b1;
			dip_autoxfer <= 1'b1;
			rst_pulse();
			apb(1'b1, omc_pkg::ADDR_STARTUP, {16'h0, st_tbl[i][15:0]});
			xfer_stall <= 1'b0;
			wait_ready();
			chk(q[1:0], st_tbl[i][17:16]);
		end
		dip_autoxfer <= 1'b0;
	end
	endtask : t_startup
	task automatic wrap_up;
	begin
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask : wrap_up
	initial
	begin
		// roughly twenty times the cycles the scenarios need
		#200000;
		failures++;
		wrap_up();
	end
	initial
	begin
		do_reset();
		t_regs();
		t_boot();
		t_startup();
		pdev.attach(omc_pkg::DEV_NONE, 2'h0, 1'b0);
		dip_any_device <= 1'b0;
		do_reset();
		t_modes();
		t_hold();
		t_battery();
		wrap_up();
	end
endmodule : omc_mode_ctrl_tb
`default_nettype wire
